// *** verilog/scl_defines.svh ***
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH

// Bank geometry
`define SCL_NUM_BANKS      12
`define SCL_BANK_W         7
`define SCL_BANKS_PER_CH   3
`define SCL_NUM_CH         4
`define SCL_SLOT_STATIC_A  2'h0
`define SCL_SLOT_STATIC_B  2'h1
`define SCL_SLOT_DYNAMIC   2'h2

// Field positions inside the transmit banks
`define SCL_CLKSEL_BIT     0
`define SCL_RATE_BIT       1
`define SCL_SELFTEST_BIT   0
`define SCL_SEC_OE_BIT     0
`define SCL_PRI_OE_BIT     1
`define SCL_RECENTRE_BIT   2

// Initialization values
`define SCL_RST_STATIC_A   7'h01
`define SCL_RST_STATIC_B   7'h01
`define SCL_RST_DYNAMIC    7'h04
`define SCL_RST_OTHER      7'h00

// PLL multipliers
`define SCL_MULT_FULL      5'h0a
`define SCL_MULT_DOUBLE    5'h14

`endif

// *** verilog/scl_pkg.sv ***
`default_nettype none
package scl_pkg;

    typedef logic [6:0] scl_bank_t;

    typedef enum logic [1:0] {
        SCL_BANK_STATIC_A = 2'b00,
        SCL_BANK_STATIC_B = 2'b01,
        SCL_BANK_DYNAMIC  = 2'b10,
        SCL_BANK_NONE     = 2'b11
    } scl_bank_kind_e;

    typedef struct packed {
        logic       clock_source_sel;
        logic       buffer_bypass;
        logic       pll_rate_sel;
        logic [4:0] pll_multiplier;
        logic       clock_out_double;
        logic       dual_edge_capture;
        logic       selftest_disable;
        logic       selftest_enable;
        logic       primary_out_enable;
        logic       secondary_out_enable;
        logic       primary_power_down;
        logic       secondary_power_down;
        logic       tx_logic_power_down;
        logic       rate_invalid;
    } scl_tx_cfg_s;

endpackage
`default_nettype wire

// *** verilog/scl_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module scl_pin_sync #(
    parameter int unsigned      W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // Pins and filtered levels
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // First stage feeds only the second
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            level_o <= RST_VAL;
        end else begin
            for (int b = 0; b < int'(W); b++) begin
                if (s2_q[b] == s3_q[b]) begin
                    level_o[b] <= s3_q[b];
                end
            end
        end
    end
endmodule // scl_pin_sync
`default_nettype wire

// *** verilog/scl_recentre.sv ***
`timescale 1ns/1ps
`default_nettype none
module scl_recentre (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Request and transmit input clock edge
    input  wire logic request_i,
    input  wire logic tclk_rise_i,
    // One-cycle re-centre pulse
    output logic      recentre_o
);
    logic pending_q;

    // Waits for a transmit input clock edge; a stopped clock holds it
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pending_q <= 1'b0;
        end else if (request_i) begin
            pending_q <= 1'b1;
        end else if (tclk_rise_i) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            recentre_o <= 1'b0;
        end else begin
            recentre_o <= pending_q && tclk_rise_i && !request_i;
        end
    end
endmodule // scl_recentre
`default_nettype wire

// *** verilog/scl_config_latch.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scl_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Twelve configuration banks, written only, never read back by host
// - Low write strobe loads data bus into bank chosen by address
// - Each bank keeps seven configuration bits
// - Three consecutive banks per channel, banks 0 to 2 for first
// - Addresses 0,1,3,4,6,7,9,10 are static banks
// - Addresses 2,5,8,11 are dynamic banks
// - Writes to one channel never touch another channel's settings
// - Reset loads every bank with its initialization value
// - Clock source select resets to 1; 1 means reference clock, bypass
// - Rate select resets to 0; multiplier 10, or 20 at 1
// - Rate 0 gives full-rate clock out, rate 1 doubles it
// - Source and rate both 1 capture data on both edges
// - Self-test disable resets to 1; writing 0 enables self-test
// - Secondary driver enable resets to 0; 1 enables it
// - Primary driver enable resets to 0; 1 enables it
// - Disabled driver powers down; both off powers down channel logic
// - Reset disables all serial output drivers
// - Re-centre bit resets to 1; writing 0 re-centres phase buffer
// - Re-centre request sampled on transmit input clock rising edges
// - Re-centre bit returns to 1 by itself after use
module scl_config_latch #(
    parameter int unsigned NUM_TX_CH = 2
) (
    // Clock and reset
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    // Configuration pins from the host
    input  wire logic [3:0]                config_addr_i,
    input  wire logic [7:0]                config_data_i,
    input  wire logic                      config_write_strobe_n_i,
    // Transmit channel pins
    input  wire logic [NUM_TX_CH-1:0]      speed_range_sel_i,
    input  wire logic [NUM_TX_CH-1:0]      tx_input_clock_i,
    // Transmit configuration
    output var  scl_pkg::scl_tx_cfg_s [NUM_TX_CH-1:0] tx_cfg_o,
    output logic [NUM_TX_CH-1:0]           phase_buffer_recentre_o,
    // Raw bank image for the receive side
    output var  scl_pkg::scl_bank_t [`SCL_NUM_BANKS-1:0] bank_image_o,
    // Write activity
    output logic                           static_write_o,
    output logic                           dynamic_write_o,
    output logic                           unmapped_write_o
);
    import scl_pkg::*;

    localparam int unsigned SW = 13 + 2 * NUM_TX_CH;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic scl_bank_kind_e bank_kind(input logic [3:0] addr);
        scl_bank_kind_e k;
        k = SCL_BANK_NONE;
        if (addr < 4'(`SCL_NUM_BANKS)) begin
            unique case (2'(addr % 4'(`SCL_BANKS_PER_CH)))
                `SCL_SLOT_STATIC_A: k = SCL_BANK_STATIC_A;
                `SCL_SLOT_STATIC_B: k = SCL_BANK_STATIC_B;
                `SCL_SLOT_DYNAMIC:  k = SCL_BANK_DYNAMIC;
                default:            k = SCL_BANK_NONE;
            endcase
        end
        return k;
    endfunction

    function automatic scl_bank_t bank_reset(input logic [3:0] addr);
        scl_bank_t v;
        v = `SCL_RST_OTHER;
        if (int'(addr / 4'(`SCL_BANKS_PER_CH)) < int'(NUM_TX_CH)) begin
            unique case (bank_kind(addr))
                SCL_BANK_STATIC_A: v = `SCL_RST_STATIC_A;
                SCL_BANK_STATIC_B: v = `SCL_RST_STATIC_B;
                SCL_BANK_DYNAMIC:  v = `SCL_RST_DYNAMIC;
                SCL_BANK_NONE:     v = `SCL_RST_OTHER;
            endcase
        end
        return v;
    endfunction

    // One-hot bank select; codes 12 to 15 select nothing
    function automatic logic [`SCL_NUM_BANKS-1:0] bank_select(
        input logic [3:0] addr
    );
        logic [`SCL_NUM_BANKS-1:0] s;
        s = '0;
        for (int i = 0; i < `SCL_NUM_BANKS; i++) begin
            s[i] = (addr == 4'(i));
        end
        return s;
    endfunction

    function automatic scl_tx_cfg_s cfg_build(
        input scl_bank_t sa,
        input scl_bank_t sb,
        input scl_bank_t dy,
        input logic      spd
    );
        scl_tx_cfg_s c;
        c = '0;
        c.clock_source_sel     = sa[`SCL_CLKSEL_BIT];
        c.buffer_bypass        = sa[`SCL_CLKSEL_BIT];
        c.pll_rate_sel         = sa[`SCL_RATE_BIT];
        c.pll_multiplier       = sa[`SCL_RATE_BIT] ? `SCL_MULT_DOUBLE
                                                   : `SCL_MULT_FULL;
        c.clock_out_double     = sa[`SCL_RATE_BIT];
        c.dual_edge_capture    = sa[`SCL_CLKSEL_BIT]
                              && sa[`SCL_RATE_BIT];
        c.selftest_disable     = sb[`SCL_SELFTEST_BIT];
        c.selftest_enable      = !sb[`SCL_SELFTEST_BIT];
        c.primary_out_enable   = dy[`SCL_PRI_OE_BIT];
        c.secondary_out_enable = dy[`SCL_SEC_OE_BIT];
        c.primary_power_down   = !dy[`SCL_PRI_OE_BIT];
        c.secondary_power_down = !dy[`SCL_SEC_OE_BIT];
        c.tx_logic_power_down  = !dy[`SCL_PRI_OE_BIT]
                              && !dy[`SCL_SEC_OE_BIT];
        // Reserved combination is flagged, not corrected
        c.rate_invalid         = sa[`SCL_RATE_BIT] && !spd;
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [SW-1:0]          sync_level;
    logic                   strobe_n_s;
    logic [3:0]             addr_s;
    logic [7:0]             data_s;
    logic [NUM_TX_CH-1:0]   spd_s;
    logic [NUM_TX_CH-1:0]   tclk_s;

    // Strobe idles high, so it leaves reset inactive
    scl_pin_sync #(
        .W       (SW),
        .RST_VAL (SW'(1))
    ) u_pin_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .pin_i   ({tx_input_clock_i, speed_range_sel_i, config_data_i,
                   config_addr_i, config_write_strobe_n_i}),
        .level_o (sync_level)
    );

    // Address and data share the strobe's latency
    assign strobe_n_s = sync_level[0];
    assign addr_s     = sync_level[4:1];
    assign data_s     = sync_level[12:5];
    assign spd_s      = sync_level[13 +: NUM_TX_CH];
    assign tclk_s     = sync_level[13 + NUM_TX_CH +: NUM_TX_CH];

    ////////////////////////////////////////////////////////////////////////
    // Write qualification

    scl_bank_kind_e wr_kind;
    logic           wr_active;
    logic           wr_hit;
    logic           wr_prev_q;
    logic           wr_start;
    logic           wr_end;
    logic [3:0]     wr_addr_q;
    logic [`SCL_NUM_BANKS-1:0] wr_sel;

    assign wr_sel    = bank_select(addr_s);
    assign wr_kind   = bank_kind(addr_s);
    assign wr_active = !strobe_n_s;
    assign wr_hit    = wr_active && (wr_kind != SCL_BANK_NONE);
    assign wr_start  = wr_active && !wr_prev_q;
    assign wr_end    = !wr_active && wr_prev_q;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wr_prev_q <= 1'b0;
        end else begin
            wr_prev_q <= wr_active;
        end
    end

    // Address of the write in progress, kept past the strobe's end
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wr_addr_q <= 4'hf;
        end else if (wr_active) begin
            wr_addr_q <= addr_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latch banks

    logic [`SCL_NUM_CH-1:0] recentre_done;

    always_comb begin
        recentre_done = '0;
        recentre_done[NUM_TX_CH-1:0] = phase_buffer_recentre_o;
    end

    // Level-sensitive: the bank follows the data bus while strobed
    always_ff @(posedge clock_i) begin
        for (int i = 0; i < `SCL_NUM_BANKS; i++) begin
            if (rst_i) begin
                bank_image_o[i] <= bank_reset(4'(i));
            end else if (wr_hit && wr_sel[i]) begin
                // Only the addressed bank moves
                bank_image_o[i] <= data_s[`SCL_BANK_W-1:0];
            end else if (bank_kind(4'(i)) == SCL_BANK_DYNAMIC
                      && recentre_done[i / `SCL_BANKS_PER_CH]) begin
                // A write in the same cycle takes precedence
                bank_image_o[i][`SCL_RECENTRE_BIT] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write activity pulses

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            static_write_o   <= 1'b0;
            dynamic_write_o  <= 1'b0;
            unmapped_write_o <= 1'b0;
        end else begin
            static_write_o   <= wr_start
                             && (wr_kind == SCL_BANK_STATIC_A
                              || wr_kind == SCL_BANK_STATIC_B);
            dynamic_write_o  <= wr_start
                             && wr_kind == SCL_BANK_DYNAMIC;
            unmapped_write_o <= wr_start
                             && wr_kind == SCL_BANK_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit input clock edges

    logic [NUM_TX_CH-1:0] tclk_prev_q;
    logic [NUM_TX_CH-1:0] tclk_rise;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tclk_prev_q <= '0;
        end else begin
            tclk_prev_q <= tclk_s;
        end
    end

    assign tclk_rise = tclk_s & ~tclk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel decode

    for (genvar c = 0; c < int'(NUM_TX_CH); c++) begin : g_ch
        localparam int BASE = c * `SCL_BANKS_PER_CH;
        localparam logic [3:0] DYN_ADDR = 4'(BASE + 2);

        logic rc_request;

        // Taken once the write ends, so the last data value decides
        assign rc_request = wr_end && wr_addr_q == DYN_ADDR
            && !bank_image_o[BASE + 2][`SCL_RECENTRE_BIT];

        scl_recentre u_recentre (
            .clock_i     (clock_i),
            .rst_i       (rst_i),
            .request_i   (rc_request),
            .tclk_rise_i (tclk_rise[c]),
            .recentre_o  (phase_buffer_recentre_o[c])
        );

        // Drivers stay off through reset
        always_ff @(posedge clock_i) begin
            if (rst_i) begin
                tx_cfg_o[c] <= cfg_build(bank_reset(4'(BASE)),
                                         bank_reset(4'(BASE + 1)),
                                         bank_reset(4'(BASE + 2)),
                                         1'b1);
            end else begin
                tx_cfg_o[c] <= cfg_build(bank_image_o[BASE],
                                         bank_image_o[BASE + 1],
                                         bank_image_o[BASE + 2],
                                         spd_s[c]);
            end
        end
    end

endmodule // scl_config_latch
`default_nettype wire

// *** tb/scl_config_latch_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module scl_config_latch_properties #(
    parameter int unsigned NUM_TX_CH = 2
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Host pins
    input wire logic [3:0] config_addr_i,
    input wire logic [7:0] config_data_i,
    input wire logic config_write_strobe_n_i,
    input wire logic [NUM_TX_CH-1:0] speed_range_sel_i,
    input wire logic [NUM_TX_CH-1:0] tx_input_clock_i,
    // Design outputs
    input wire scl_pkg::scl_tx_cfg_s [NUM_TX_CH-1:0] tx_cfg_o,
    input wire logic [NUM_TX_CH-1:0] phase_buffer_recentre_o,
    input wire scl_pkg::scl_bank_t [11:0] bank_image_o,
    input wire logic static_write_o,
    input wire logic dynamic_write_o,
    input wire logic unmapped_write_o
);
    import scl_pkg::*;
    scl_tx_cfg_s c0;
    scl_tx_cfg_s c1;
    assign c0 = tx_cfg_o[0];
    assign c1 = tx_cfg_o[1];
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    sequence s_pulse; $rose(phase_buffer_recentre_o[0]); endsequence
    sequence s_back; ##[1:2] bank_image_o[2][2]; endsequence
    // Strobe high this long flushes the pin filter
    sequence s_idle; config_write_strobe_n_i [*8]; endsequence

    property p_rst_vals;
        $fell(rst_i) |-> c0.clock_source_sel && c0.selftest_disable &&
            !c0.pll_rate_sel && bank_image_o[2] == 7'h04;
    endproperty
    a_rst_vals: assert property (p_rst_vals)
        else $error("reset values wrong");
    property p_drv_off;
        $fell(rst_i) |-> !c0.primary_out_enable && !c0.secondary_out_enable
            && !c1.primary_out_enable && !c1.secondary_out_enable;
    endproperty
    a_drv_off: assert property (p_drv_off)
        else $error("driver on after reset");
    property p_mult;
        c0.pll_multiplier == (c0.pll_rate_sel ? 5'h14 : 5'h0a);
    endproperty
    a_mult: assert property (p_mult)
        else $error("multiplier wrong");
    property p_dual;
        c0.dual_edge_capture == (c0.clock_source_sel && c0.pll_rate_sel);
    endproperty
    a_dual: assert property (p_dual)
        else $error("dual edge capture wrong");
    property p_power;
        c1.tx_logic_power_down == !(c1.primary_out_enable ||
            c1.secondary_out_enable) && c1.primary_power_down != c1.primary_out_enable;
    endproperty
    a_power: assert property (p_power)
        else $error("power down wrong");
    property p_selftest;
        c1.selftest_enable != c1.selftest_disable;
    endproperty
    a_selftest: assert property (p_selftest)
        else $error("self-test enable wrong");
    property p_one; s_pulse |=> !phase_buffer_recentre_o[0]; endproperty
    a_one: assert property (p_one)
        else $error("recentre pulse too long");
    property p_back; s_pulse |-> s_back; endproperty
    a_back: assert property (p_back)
        else $error("recentre bit not restored");
    property p_idle; s_idle |=> $stable(bank_image_o[0]); endproperty
    a_idle: assert property (p_idle)
        else $error("bank changed without strobe");
    property p_unmapped; unmapped_write_o |=> $stable(bank_image_o); endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped write changed a bank");
endmodule // scl_config_latch_properties
`default_nettype wire

// *** tb/scl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module scl_host_model (
    // Clock and speed pins seen by the host
    input  wire logic       clock_i,
    input  wire logic [1:0] speed_range_sel_i,
    // Configuration pins
    output logic [3:0]      config_addr_o,
    output logic [7:0]      config_data_o,
    output logic            config_write_strobe_n_o
);
    initial begin
        config_addr_o = 4'h0;
        config_data_o = 8'h00;
        config_write_strobe_n_o = 1'b1;
    end
    // Slow strobe: the device filters its pins over several cycles
    task automatic write(input logic [3:0] a, input logic [7:0] d,
                         output logic [6:0] sent);
        logic [7:0] v;
        v = {1'b0, d[6:0]};
        if ((a == 4'h0 && !speed_range_sel_i[0]) ||
            (a == 4'h3 && !speed_range_sel_i[1]))
            v[1] = 1'b0;
        @(negedge clock_i);
        config_addr_o = a;
        config_data_o = v;
        @(negedge clock_i);
        config_write_strobe_n_o = 1'b0;
        repeat (4) @(negedge clock_i);
        config_write_strobe_n_o = 1'b1;
        repeat (6) @(negedge clock_i);
        // Released bus shows no stale value
        config_addr_o = ~a;
        config_data_o = ~v;
        repeat (18) @(negedge clock_i);
        sent = v[6:0];
    endtask
endmodule // scl_host_model
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import scl_pkg::*;
    logic              clock_i;
    logic              rst_i;
    logic [3:0]        addr;
    logic [7:0]        data;
    logic              strobe_n;
    logic [1:0]        spd;
    logic [1:0]        tclk;
    logic [1:0]        rc;
    scl_tx_cfg_s [1:0] cfg;
    scl_bank_t [11:0]  img;
    logic              sw;
    logic              dw;
    logic              uw;
    int                fails;
    int                num_checks;
    int                cycles;
    int                bank[12];
    int                exp_p[2];
    int                got_p[2];
    int                exp_w[3];
    int                got_w[3];

    always #50 clock_i = ~clock_i;
    always @(negedge clock_i) begin
        cycles++;
        if (cycles % 4 == 0) tclk[0] <= ~tclk[0];
        if (cycles % 5 == 0) tclk[1] <= ~tclk[1];
        if (cycles == 4000) begin
            fails++;
            report_and_stop();
        end
    end
    always @(posedge clock_i) begin
        for (int c = 0; c < 2; c++)
            if (rc[c] === 1'b1) got_p[c]++;
        if (sw === 1'b1) got_w[0]++;
        if (dw === 1'b1) got_w[1]++;
        if (uw === 1'b1) got_w[2]++;
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic scl_tx_cfg_s exp_cfg(int c);
        logic [6:0] a;
        logic [6:0] b;
        logic [6:0] d;
        a = 7'(bank[3*c]);
        b = 7'(bank[3*c+1]);
        d = 7'(bank[3*c+2]);
        return '{clock_source_sel: a[0], buffer_bypass: a[0],
            pll_rate_sel: a[1], pll_multiplier: a[1] ? 5'h14 : 5'h0a,
            clock_out_double: a[1], dual_edge_capture: a[0] & a[1],
            selftest_disable: b[0], selftest_enable: ~b[0],
            primary_out_enable: d[1], secondary_out_enable: d[0],
            primary_power_down: ~d[1], secondary_power_down: ~d[0],
            tx_logic_power_down: ~(d[1] | d[0]),
            rate_invalid: a[1] & ~spd[c]};
    endfunction
    task automatic chk_bank(int i, scl_bank_t got);
        num_checks++;
        if (got !== 7'(bank[i])) begin
            fails++;
            $display("MISMATCH bank %0d exp %h seen %h", i, 7'(bank[i]), got);
        end
    endtask
    task automatic chk_cfg(int c, scl_tx_cfg_s got);
        num_checks++;
        if (got !== exp_cfg(c)) begin
            fails++;
            $display("MISMATCH tx_cfg %0d exp %h seen %h", c, exp_cfg(c), got);
        end
    endtask
    task automatic chk_cnt(int c);
        num_checks++;
        if (got_p[c] != exp_p[c]) begin
            fails++;
            $display("MISMATCH pulses %0d exp %0d seen %0d", c, exp_p[c],
                     got_p[c]);
        end
    endtask
    task automatic chk_wr(int k);
        num_checks++;
        if (got_w[k] != exp_w[k]) begin
            fails++;
            $display("MISMATCH writes %0d exp %0d seen %0d", k, exp_w[k],
                     got_w[k]);
        end
    endtask
    task automatic check_all();
        for (int k = 0; k < 3; k++)
            chk_wr(k);
        for (int i = 0; i < 12; i++)
            chk_bank(i, img[i]);
        for (int c = 0; c < 2; c++) begin
            chk_cfg(c, cfg[c]);
            chk_cnt(c);
        end
    endtask
    task automatic do_write(logic [3:0] a, logic [7:0] d);
        logic [6:0] v;
        u_host.write(a, d, v);
        // One activity pulse per write, kind taken from the address
        exp_w[(a > 4'hb) ? 2 : (a % 3 == 2) ? 1 : 0]++;
        if (a < 4'hc) bank[a] = v;
        // Recentre bit returns to 1 by itself once used
        if (a == 4'h2 || a == 4'h5) begin
            if (!v[2]) exp_p[a/3]++;
            bank[a] = v | 7'h04;
        end
        check_all();
    endtask
    task automatic apply_reset();
        rst_i = 1'b1;
        repeat (16) @(negedge clock_i);
        rst_i = 1'b0;
        for (int i = 0; i < 12; i++)
            bank[i] = (i >= 6) ? 0 : (i % 3 == 2) ? 4 : 1;
        check_all();
    endtask
    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        rst_i = 1'b1;
        tclk = 2'b00;
        spd = 2'($urandom(32'h8b389ea6));
        apply_reset();
        for (int a = 0; a < 16; a++) do_write(4'(a), 8'($urandom));
        spd = 2'b11;
        for (int m = 0; m < 4; m++) do_write(4'h0, 8'(m));
        for (int m = 0; m < 8; m++) do_write(4'h5, 8'(m));
        // Speed dropped under a set rate flags the reserved mix
        spd = 2'b00;
        repeat (8) @(negedge clock_i);
        check_all();
        for (int k = 0; k < 20; k++) begin
            spd = 2'($urandom);
            do_write(4'($urandom % 12), 8'($urandom));
        end
        apply_reset();
        do_write(4'h2, 8'h03);
        report_and_stop();
    end

    scl_host_model u_host (.clock_i(clock_i), .speed_range_sel_i(spd),
        .config_addr_o(addr), .config_data_o(data),
        .config_write_strobe_n_o(strobe_n));
    scl_config_latch #(.NUM_TX_CH(2)) dut (.clock_i(clock_i),
        .rst_i(rst_i), .config_addr_i(addr), .config_data_i(data),
        .config_write_strobe_n_i(strobe_n), .speed_range_sel_i(spd),
        .tx_input_clock_i(tclk), .tx_cfg_o(cfg),
        .phase_buffer_recentre_o(rc), .bank_image_o(img),
        .static_write_o(sw), .dynamic_write_o(dw), .unmapped_write_o(uw));
endmodule // tb_top

bind scl_config_latch scl_config_latch_properties #(
    .NUM_TX_CH(NUM_TX_CH)) u_props (.clock_i(clock_i), .rst_i(rst_i),
    .config_addr_i(config_addr_i), .config_data_i(config_data_i),
    .config_write_strobe_n_i(config_write_strobe_n_i),
    .speed_range_sel_i(speed_range_sel_i),
    .tx_input_clock_i(tx_input_clock_i), .tx_cfg_o(tx_cfg_o),
    .phase_buffer_recentre_o(phase_buffer_recentre_o),
    .bank_image_o(bank_image_o), .static_write_o(static_write_o),
    .dynamic_write_o(dynamic_write_o), .unmapped_write_o(unmapped_write_o));
`default_nettype wire
